// ### smbus_pec_aux_slave_regs.sv
/*
 * Check-byte, own target address, received message word, auxiliary status
 * and control registers of a two-wire management bus controller, with the
 * 32-byte block storage, behind an APB slave.
 * Assumes a bus engine on the same clock driving eng_i; rst_i is the
 * resume-well reset. The PCI bus reset is not connected, so it never
 * disturbs these registers.
 */
// Functional notes
// - received check byte captured into register
// - decode own 7-bit address, bit7 reserved
// - own address resets to 44h
// - only resume-well reset clears own address
// - read-only word, byte1 high, byte0 low
// - word resets 0000h on resume-well reset
// - check-byte mismatch sets crc mismatch flag
// - mismatch flag also raises device error
// - abort in crc phase sets flag
// - write one clears mismatch flag
// - buffer enable makes block data pointer
// - up to 32 bytes before completion
// - auto-append sends computed check byte
// - buffer disabled, block data single byte
// - host control read zeroes pointer; access increments
`timescale 1ns/100ps
`default_nettype none
`include "smb_aux_map.svh"

module smbus_pec_aux_slave_regs
   import smb_aux_pkg::*;
#(
   parameter int BUF_DEPTH = `BLOCK_BUFFER_DEPTH
) (
   input  wire logic        mclk_i,                // 40 MHz clock
   input  wire logic        rst_i,                 // resume-well reset, async
   input  wire logic        psel,                  // apb select
   input  wire logic        penable,               // apb access phase
   input  wire logic        pwrite,                // apb direction
   input  wire logic [11:0] paddr,                 // apb byte address
   input  wire logic [31:0] pwdata,                // apb write data
   output logic      [31:0] prdata,                // apb read data
   output logic             pready,                // apb ready
   output logic             pslverr,               // apb unmapped access
   input  wire eng_in_t     eng_i,                 // bus engine events
   output logic             own_addr_match_o,      // address byte hit us
   output logic             device_error_set_o,    // pulse to host status
   output logic             crc_auto_append_o,     // engine appends crc
   output logic             block_buffer_enable_o, // block storage active
   output logic      [7:0]  tx_pec_o,              // check byte to send
   output logic      [7:0]  buf_byte_o,            // block byte to send
   output logic             block_done_o           // block completion pulse
);

   localparam int IW = $clog2(BUF_DEPTH);
   // reset words kept whole so each flag takes its own bit, not a truncation
   localparam logic [7:0] AUXILIARY_STATUS_RST = `RST_AUX_STATUS;
   localparam logic [7:0] AUXILIARY_CONTROL_RST = `RST_AUX_CONTROL;

   if (BUF_DEPTH < 2 || BUF_DEPTH > 256 || (1 << IW) != BUF_DEPTH) begin : g_chk
      $error("BUF_DEPTH must be a power of two from 2 to 256");
   end

   function automatic logic [7:0] reg_index(input logic [11:0] a);
      return a[9:2];
   endfunction : reg_index

   function automatic logic mapped(input logic [7:0] idx);
      case (idx)
         `IDX_HOST_CONTROL, `IDX_BLOCK_DATA, `IDX_PACKET_CHECK, `IDX_OWN_TARGET,
         `IDX_RECEIVED_WORD, `IDX_AUX_STATUS, `IDX_AUX_CONTROL: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : mapped

   apb_state_t  st_r,      st_nxt;
   logic [31:0] prdata_r,  prdata_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic        ready_r,   ready_nxt;
   logic [7:0]  pec_r,     pec_nxt;
   logic [6:0]  own_r,     own_nxt;
   logic [15:0] word_r,    word_nxt;
   logic        crc_mismatch_flag_r,    crc_mismatch_flag_nxt;
   logic        aac_r,     aac_nxt;
   logic        block_buffer_enable_r,    block_buffer_enable_nxt;
   logic [IW-1:0] sptr_r,  sptr_nxt;
   logic [IW-1:0] eidx_r,  eidx_nxt;
   logic [7:0]  mem_r   [BUF_DEPTH];
   logic [7:0]  mem_nxt [BUF_DEPTH];
   logic        match_r,   match_nxt;
   logic        device_error_flag_r,    device_error_flag_nxt;
   logic [7:0]  txpec_r,   txpec_nxt;
   logic [7:0]  bbyte_r,   bbyte_nxt;
   logic        done_r,    done_nxt;
   logic [7:0]  crc_val;

   logic [7:0]  idx;
   logic        acc_done;
   logic        sw_wr;
   logic        sw_rd;
   logic        crc_err_evt;
   logic [IW-1:0] sw_slot;
   logic [IW-1:0] eng_slot;

   crc8_unit u_crc (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .clear_i (eng_i.crc_clear),
      .valid_i (eng_i.byte_valid),
      .data_i  (eng_i.bus_byte),
      .crc_o   (crc_val)
   );

   assign idx      = reg_index(paddr);
   assign acc_done = (st_r == APB_DONE);
   assign sw_wr    = acc_done && pwrite && mapped(idx);
   assign sw_rd    = acc_done && !pwrite && mapped(idx);
   // with the buffer off, both sides share slot 0 as the single data byte
   assign sw_slot  = block_buffer_enable_r ? sptr_r : '0;
   assign eng_slot = block_buffer_enable_r ? eidx_r : '0;

   // received check byte differs from crc of the preceding bytes, or an
   // abort hit the crc portion or came after the slave's last data bit
   assign crc_err_evt = (eng_i.rx_pec_valid && (eng_i.bus_byte != crc_val))
                     || (eng_i.abort && (eng_i.in_crc_phase || eng_i.final_bit_rcvd));

   // apb: setup, two wait cycles (penable sampled, then the registered read data), then ready
   always_comb begin
      st_nxt      = st_r;
      prdata_nxt  = prdata_r;
      pslverr_nxt = pslverr_r;
      case (st_r)
         APB_IDLE: begin
            if (psel && penable) begin
               st_nxt = APB_ACCESS;
            end
         end
         APB_ACCESS: begin
            st_nxt      = APB_DONE;
            pslverr_nxt = !mapped(idx);
            prdata_nxt  = 32'h0000_0000;
            if (!pwrite) begin
               case (idx)
                  `IDX_BLOCK_DATA:    prdata_nxt[7:0]  = mem_r[sw_slot];
                  `IDX_PACKET_CHECK:  prdata_nxt[7:0]  = pec_r;
                  `IDX_OWN_TARGET:    prdata_nxt[6:0]  = own_r;
                  `IDX_RECEIVED_WORD: prdata_nxt[15:0] = word_r;
                  `IDX_AUX_STATUS:    prdata_nxt[`BIT_CRC_MISMATCH] = crc_mismatch_flag_r;
                  `IDX_AUX_CONTROL: begin
                     prdata_nxt[`BIT_AUTO_APPEND]  = aac_r;
                     prdata_nxt[`BIT_BLOCK_BUFFER] = block_buffer_enable_r;
                  end
                  default:            prdata_nxt = 32'h0000_0000;
               endcase
            end
         end
         APB_DONE: begin
            st_nxt      = APB_IDLE;
            pslverr_nxt = 1'b0;
         end
         default: begin
            st_nxt = APB_IDLE;
         end
      endcase
      // ready gets a flop of its own so the port is not a state decode
      ready_nxt = (st_nxt == APB_DONE);
   end

   // software and engine side of the registers and block storage
   always_comb begin
      pec_nxt   = pec_r;
      own_nxt   = own_r;
      word_nxt  = word_r;
      crc_mismatch_flag_nxt  = crc_mismatch_flag_r;
      aac_nxt   = aac_r;
      block_buffer_enable_nxt  = block_buffer_enable_r;
      sptr_nxt  = sptr_r;
      eidx_nxt  = eidx_r;
      mem_nxt   = mem_r;
      match_nxt = 1'b0;
      device_error_flag_nxt  = 1'b0;
      done_nxt  = 1'b0;
      bbyte_nxt = bbyte_r;
      if (sw_wr) begin
         case (idx)
            `IDX_BLOCK_DATA:   mem_nxt[sw_slot] = pwdata[7:0];
            `IDX_PACKET_CHECK: pec_nxt = pwdata[7:0];
            `IDX_OWN_TARGET:   own_nxt = pwdata[`OWN_ADDR_MSB:0];
            `IDX_AUX_STATUS: begin
               if (pwdata[`BIT_CRC_MISMATCH]) begin
                  crc_mismatch_flag_nxt = 1'b0;
               end
            end
            `IDX_AUX_CONTROL: begin
               aac_nxt  = pwdata[`BIT_AUTO_APPEND];
               block_buffer_enable_nxt = pwdata[`BIT_BLOCK_BUFFER];
            end
            default: begin
               own_nxt = own_r;
            end
         endcase
      end
      if (acc_done && idx == `IDX_BLOCK_DATA && block_buffer_enable_r) begin
         sptr_nxt = sptr_r + 1'b1;
      end
      if (sw_rd && idx == `IDX_HOST_CONTROL) begin
         sptr_nxt = '0;
      end
      // capture wins over a software write to the check-byte register in the same cycle
      if (eng_i.rx_pec_valid) begin
         pec_nxt = eng_i.bus_byte;
      end
      if (eng_i.word_valid) begin
         word_nxt = eng_i.word;
      end
      if (crc_err_evt) begin
         crc_mismatch_flag_nxt = 1'b1;
         device_error_flag_nxt = 1'b1;
      end
      if (eng_i.addr_valid) begin
         match_nxt = (eng_i.addr_byte[7:1] == own_r);
      end
      if (eng_i.buf_start) begin
         eidx_nxt = '0;
      end else if (eng_i.buf_wr || eng_i.buf_rd) begin
         if (eng_i.buf_wr) begin
            mem_nxt[eng_slot] = eng_i.bus_byte;
         end else begin
            bbyte_nxt = mem_r[eng_slot];
         end
         if (block_buffer_enable_r) begin
            eidx_nxt = eidx_r + 1'b1;
         end
         // completion after the count runs out or the storage is full;
         // without the buffer every byte needs software attention
         done_nxt = eng_i.last_byte || !block_buffer_enable_r
                 || (eidx_r == IW'(BUF_DEPTH - 1));
      end
   end

   // auto-append sends the running crc, else the check-byte register, whether software wrote it or it was captured
   assign txpec_nxt = aac_r ? crc_val : pec_r;

   // rst_i is the resume-well reset; no other reset reaches these flops
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r      <= APB_IDLE;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
         ready_r   <= 1'b0;
         pec_r     <= `RST_PACKET_CHECK;
         own_r     <= 7'(`RST_OWN_TARGET);
         word_r    <= `RST_RECEIVED_WORD;
         crc_mismatch_flag_r    <= AUXILIARY_STATUS_RST[`BIT_CRC_MISMATCH];
         aac_r     <= AUXILIARY_CONTROL_RST[`BIT_AUTO_APPEND];
         block_buffer_enable_r    <= AUXILIARY_CONTROL_RST[`BIT_BLOCK_BUFFER];
         sptr_r    <= '0;
         eidx_r    <= '0;
         for (int i = 0; i < BUF_DEPTH; i++) begin
            mem_r[i] <= `RST_BLOCK_BYTE;
         end
         match_r   <= 1'b0;
         device_error_flag_r    <= 1'b0;
         txpec_r   <= `RST_PACKET_CHECK;
         bbyte_r   <= `RST_BLOCK_BYTE;
         done_r    <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         ready_r   <= ready_nxt;
         pec_r     <= pec_nxt;
         own_r     <= own_nxt;
         word_r    <= word_nxt;
         crc_mismatch_flag_r    <= crc_mismatch_flag_nxt;
         aac_r     <= aac_nxt;
         block_buffer_enable_r    <= block_buffer_enable_nxt;
         sptr_r    <= sptr_nxt;
         eidx_r    <= eidx_nxt;
         mem_r     <= mem_nxt;
         match_r   <= match_nxt;
         device_error_flag_r    <= device_error_flag_nxt;
         txpec_r   <= txpec_nxt;
         bbyte_r   <= bbyte_nxt;
         done_r    <= done_nxt;
      end
   end

   assign prdata                = prdata_r;
   assign pready                = ready_r;
   assign pslverr               = pslverr_r;
   assign own_addr_match_o      = match_r;
   assign device_error_set_o    = device_error_flag_r;
   assign crc_auto_append_o     = aac_r;
   assign block_buffer_enable_o = block_buffer_enable_r;
   assign tx_pec_o              = txpec_r;
   assign buf_byte_o            = bbyte_r;
   assign block_done_o          = done_r;

endmodule : smbus_pec_aux_slave_regs
`default_nettype wire

// ### smb_aux_map.svh
/*
 * Register indices, field positions, reset values and constants of the
 * check-byte, target-address, message-word and auxiliary registers.
 * Assumes inclusion by bare name; byte address on APB is four times the index.
 */
`ifndef SMB_AUX_MAP_SVH
`define SMB_AUX_MAP_SVH

`define IDX_HOST_CONTROL     8'h02
`define IDX_BLOCK_DATA       8'h07
`define IDX_PACKET_CHECK     8'h08
`define IDX_OWN_TARGET       8'h09
`define IDX_RECEIVED_WORD    8'h0a
`define IDX_AUX_STATUS       8'h0c
`define IDX_AUX_CONTROL      8'h0d

`define RST_PACKET_CHECK     8'h00
`define RST_OWN_TARGET       8'h44
`define RST_RECEIVED_WORD    16'h0000
`define RST_AUX_STATUS       8'h00
`define RST_AUX_CONTROL      8'h00
`define RST_BLOCK_BYTE       8'h00

`define BIT_CRC_MISMATCH     0
`define BIT_AUTO_APPEND      0
`define BIT_BLOCK_BUFFER     1
`define OWN_ADDR_MSB         6
`define BLOCK_BUFFER_DEPTH   32

`define CRC8_POLY            8'h07
`define CRC8_INIT            8'h00

`endif

// ### smb_aux_pkg.sv
/*
 * Types shared by the auxiliary register block and its bus engine port.
 * Assumes the engine runs on the same clock as the register block.
 */
package smb_aux_pkg;

   // events and data from the bus engine, one clock domain
   typedef struct packed {
      logic       crc_clear;       // start of transaction, restart crc
      logic       byte_valid;      // one bus byte (addresses included) for the crc
      logic [7:0] bus_byte;        // byte on the bus, also the received check byte
      logic       rx_pec_valid;    // received check byte present on bus_byte
      logic       abort;           // software abort reached the engine
      logic       in_crc_phase;    // engine is inside the check-byte portion
      logic       final_bit_rcvd;  // last data bit from the slave has arrived
      logic       addr_valid;      // slave address byte present on addr_byte
      logic [7:0] addr_byte;       // 7-bit address in 7:1, direction in 0
      logic       word_valid;      // message word from an external master
      logic [15:0] word;           // high byte in 15:8, low byte in 7:0
      logic       buf_start;       // block transfer starts, engine index to 0
      logic       buf_wr;          // store bus_byte into block storage
      logic       buf_rd;          // fetch next block byte for sending
      logic       last_byte;       // byte count exhausted with this byte
   } eng_in_t;

   typedef enum logic [1:0] {
      APB_IDLE   = 2'b00,
      APB_ACCESS = 2'b01,
      APB_DONE   = 2'b10
   } apb_state_t;

endpackage : smb_aux_pkg

// ### crc8_unit.sv
/*
 * Byte-serial crc-8, polynomial x^8+x^2+x+1, msb first.
 * Assumes clear and valid are single-cycle strobes on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "smb_aux_map.svh"

module crc8_unit (
   input  wire logic       mclk_i,    // block clock
   input  wire logic       rst_i,     // async reset, active high
   input  wire logic       clear_i,   // restart the crc
   input  wire logic       valid_i,   // fold data_i in
   input  wire logic [7:0] data_i,    // byte to fold
   output logic      [7:0] crc_o      // running crc
);

   logic [7:0] crc_r;
   logic [7:0] crc_nxt;

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ `CRC8_POLY) : (r << 1);
      end
      return r;
   endfunction : crc_step

   always_comb begin
      crc_nxt = crc_r;
      if (clear_i) begin
         crc_nxt = `CRC8_INIT;
      end else if (valid_i) begin
         crc_nxt = crc_step(crc_r, data_i);
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         crc_r <= `CRC8_INIT;
      end else begin
         crc_r <= crc_nxt;
      end
   end

   assign crc_o = crc_r;

endmodule : crc8_unit
`default_nettype wire

// ### smbus_pec_aux_slave_regs_properties.sv
/* Port checker of the aux register block.
   Assumes a bind onto the top module and one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module smb_aux_checker
   import smb_aux_pkg::*;
#(
   parameter int BUF_DEPTH = 32
) (
   input wire logic        mclk_i,                // clock
   input wire logic        rst_i,                 // reset
   input wire logic        psel,                  // apb
   input wire logic        penable,               // apb
   input wire logic        pwrite,                // apb
   input wire logic [11:0] paddr,                 // apb
   input wire logic [31:0] pwdata,                // apb
   input wire logic [31:0] prdata,                // apb
   input wire logic        pready,                // apb
   input wire logic        pslverr,               // apb
   input wire eng_in_t     eng_i,                 // engine
   input wire logic        own_addr_match_o,      // hit
   input wire logic        device_error_set_o,    // error
   input wire logic        crc_auto_append_o,     // append
   input wire logic        block_buffer_enable_o, // buffer
   input wire logic [7:0]  tx_pec_o,              // check byte
   input wire logic [7:0]  buf_byte_o,            // block byte
   input wire logic        block_done_o           // done
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire logic [7:0] idx = paddr[9:2];
   // the output moves a cycle after the write completes, when psel may already be low, hence two past depths
   wire logic ctl_wr = psel && pwrite && idx == 8'h0d;

   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   apb_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 !pready ##1 pready)
      else $error("pready not on the third cycle");
   err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer not clean");
   rsv_read_a: assert property (pready && !pwrite && !pslverr |->
      (idx == 8'h0c -> prdata[31:1] == '0) && (idx == 8'h0d -> prdata[31:2] == '0)
      && (idx == 8'h09 -> prdata[31:7] == '0) && (idx == 8'h0a -> prdata[31:16] == '0))
      else $error("reserved bits read nonzero");
   match_cause_a: assert property (own_addr_match_o |-> $past(eng_i.addr_valid))
      else $error("address hit without address byte");
   abort_err_a: assert property (eng_i.abort && (eng_i.in_crc_phase ||
      eng_i.final_bit_rcvd) |=> device_error_set_o)
      else $error("abort in check portion missed");
   device_error_flag_cause_a: assert property (device_error_set_o |-> $past(eng_i.rx_pec_valid || eng_i.abort))
      else $error("device error without cause");
   ctl_change_a: assert property ($changed({crc_auto_append_o, block_buffer_enable_o})
      |-> $past(ctl_wr) || $past(ctl_wr, 2))
      else $error("control output moved without a write");
   done_cause_a: assert property (block_done_o |-> $past(eng_i.buf_wr || eng_i.buf_rd))
      else $error("block done without block access");
endmodule : smb_aux_checker
`default_nettype wire

// ### smb_engine_model.sv
/* Bus-side engine model: strobes bus bytes and events into the block.
   Assumes the bench calls its tasks from one process at a time. */
`timescale 1ns/100ps
`default_nettype none
module smb_engine_model
   import smb_aux_pkg::*;
(
   input  wire logic    mclk_i, // clock
   output var eng_in_t  eng_o   // engine events
);
   initial eng_o = '0;

   // data fields are inverted on release so a stale byte never looks valid
   task automatic pulse(input eng_in_t v);
      eng_in_t q;
      q = '0;
      q.bus_byte = ~v.bus_byte;
      q.addr_byte = ~v.addr_byte;
      q.word = ~v.word;
      @(posedge mclk_i);
      eng_o <= v;
      @(posedge mclk_i);
      eng_o <= q;
   endtask : pulse

   task automatic frame(input logic [7:0] b [3], input logic [7:0] pec, input logic rx);
      eng_in_t v;
      v = '0;
      v.crc_clear = 1'b1;
      pulse(v);
      for (int i = 0; i < 3; i++) begin
         v = '0;
         v.byte_valid = 1'b1;
         v.bus_byte = b[i];
         pulse(v);
      end
      v = '0;
      v.rx_pec_valid = 1'b1;
      v.bus_byte = pec;
      if (rx) pulse(v);
   endtask : frame

   // 0 address, 1 word, 2 block start, 3 block fetch, 5 block store, else abort
   task automatic evt(input int k, input logic [15:0] d);
      eng_in_t v;
      v = '0;
      case (k)
         0: v.addr_valid = 1'b1;
         1: v.word_valid = 1'b1;
         2: v.buf_start = 1'b1;
         3: v.buf_rd = 1'b1;
         5: v.buf_wr = 1'b1;
         default: v.abort = 1'b1;
      endcase
      v.addr_byte = d[7:0];
      v.bus_byte = d[7:0];
      v.last_byte = d[8];
      v.word = d;
      v.in_crc_phase = d[0];
      v.final_bit_rcvd = d[1];
      pulse(v);
   endtask : evt
endmodule : smb_engine_model
`default_nettype wire

// ### tb_smbus_pec_aux_slave_regs.sv
/* Self-checking bench of the aux register block.
   Assumes the engine model and checker files are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_smbus_pec_aux_slave_regs;
   import smb_aux_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic [7:0]  tx_pec_o, buf_byte_o;
   logic        pready, pslverr, own_addr_match_o, device_error_set_o;
   logic        crc_auto_append_o, block_buffer_enable_o, block_done_o;
   eng_in_t     eng_i;
   int          n_errors = 0;
   int          compares = 0;
   logic [33:0] exq [$];

   always #12.5 mclk_i = ~mclk_i;

   smbus_pec_aux_slave_regs #(.BUF_DEPTH(32)) i_dut (.mclk_i, .rst_i, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .eng_i, .own_addr_match_o,
      .device_error_set_o, .crc_auto_append_o, .block_buffer_enable_o, .tx_pec_o,
      .buf_byte_o, .block_done_o);
   smb_engine_model i_eng (.mclk_i(mclk_i), .eng_o(eng_i));

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      c = c ^ b;
      for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      return c;
   endfunction : crc8

   task automatic finish_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   task automatic do_reset();
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   // one apb transfer; the expected answer is noted before it starts
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] x, input logic e);
      int k;
      exq.push_back({!w, e, x});
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k == 20) n_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0, 1'b0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0, x, 1'b0);
   endtask : rd

   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      compares++;
      if (g !== x) begin
         n_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
      end
   endtask : chk

   always @(posedge mclk_i) begin : mon
      logic [33:0] e;
      if (pready === 1'b1 && exq.size() > 0) begin
         e = exq.pop_front();
         compares++;
         if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
            n_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e[32:0], {pslverr, prdata});
         end
      end
   end

   initial begin
      #300000;
      n_errors++;
      finish_test();
   end

   initial begin
      logic [7:0]  r, c;
      logic [7:0]  bb [3];
      logic [15:0] w;
      void'($urandom(5040));
      do_reset();
      rd(12'h020, 32'h00);
      rd(12'h024, 32'h44);
      rd(12'h028, 32'h0000);
      rd(12'h030, 32'h00);
      rd(12'h034, 32'h00);
      xfer(1'b0, 12'h03c, 32'h0, 32'h0, 1'b1);
      r = 8'($urandom);
      wr(12'h024, {24'h0, 1'b1, r[6:0]});
      rd(12'h024, {25'h0, r[6:0]});
      wr(12'h028, 32'hffff);
      rd(12'h028, 32'h0000);
      i_eng.evt(0, {8'h0, r[6:0], 1'b1});
      #1 chk({7'h0, own_addr_match_o}, 8'h01);
      i_eng.evt(0, {8'h0, r[6:0] ^ 7'h01, 1'b0});
      #1 chk({7'h0, own_addr_match_o}, 8'h00);
      c = 8'($urandom);
      wr(12'h020, {24'h0, c});
      rd(12'h020, {24'h0, c});
      bb[0] = {r[6:0], 1'b1};
      bb[1] = 8'($urandom);
      bb[2] = 8'($urandom);
      c = crc8(crc8(crc8(8'h00, bb[0]), bb[1]), bb[2]);
      i_eng.frame(bb, c, 1'b1);
      #1 chk({7'h0, device_error_set_o}, 8'h00);
      rd(12'h030, 32'h0);
      rd(12'h020, {24'h0, c});
      i_eng.frame(bb, c ^ 8'h80, 1'b1);
      #1 chk({7'h0, device_error_set_o}, 8'h01);
      rd(12'h030, 32'h1);
      rd(12'h020, {24'h0, c ^ 8'h80});
      wr(12'h030, 32'h0);
      rd(12'h030, 32'h1);
      wr(12'h030, 32'hff);
      rd(12'h030, 32'h0);
      for (int i = 0; i < 4; i++) begin
         i_eng.evt(4, 16'(i));
         #1 chk({7'h0, device_error_set_o}, {7'h0, i != 0});
         rd(12'h030, {31'h0, i != 0});
         wr(12'h030, 32'h1);
      end
      w = 16'($urandom);
      i_eng.evt(1, w);
      rd(12'h028, {16'h0, w});
      wr(12'h034, 32'hfd);
      #1 chk({6'h0, block_buffer_enable_o, crc_auto_append_o}, 8'h01);
      rd(12'h034, 32'h01);
      i_eng.frame(bb, 8'h00, 1'b0);
      @(posedge mclk_i);
      #1 chk(tx_pec_o, c);
      wr(12'h034, 32'h02);
      #1 chk({6'h0, block_buffer_enable_o, crc_auto_append_o}, 8'h02);
      rd(12'h008, 32'h0);
      for (int i = 0; i < 3; i++) begin
         bb[i] = 8'($urandom);
         wr(12'h01c, {24'h0, bb[i]});
      end
      rd(12'h008, 32'h0);
      for (int i = 0; i < 3; i++) rd(12'h01c, {24'h0, bb[i]});
      i_eng.evt(2, 16'h0);
      for (int i = 0; i < 32; i++) begin
         i_eng.evt(3, 16'h0);
         #1 chk({7'h0, block_done_o}, {7'h0, i == 31});
         if (i < 3) chk(buf_byte_o, bb[i]);
      end
      i_eng.evt(2, 16'h0);
      i_eng.evt(5, {8'h0, bb[2]});
      #1 chk({7'h0, block_done_o}, 8'h00);
      i_eng.evt(5, {8'h1, bb[0]});
      #1 chk({7'h0, block_done_o}, 8'h01);
      rd(12'h008, 32'h0);
      rd(12'h01c, {24'h0, bb[2]});
      rd(12'h01c, {24'h0, bb[0]});
      wr(12'h034, 32'h0);
      repeat (2) @(posedge mclk_i);
      #1 chk(tx_pec_o, c ^ 8'h80);
      wr(12'h01c, {24'h0, bb[1]});
      wr(12'h01c, {24'h0, bb[2]});
      rd(12'h01c, {24'h0, bb[2]});
      rd(12'h01c, {24'h0, bb[2]});
      wr(12'h024, 32'h11);
      do_reset();
      rd(12'h024, 32'h44);
      rd(12'h028, 32'h0000);
      finish_test();
   end
endmodule : tb_smbus_pec_aux_slave_regs

bind smbus_pec_aux_slave_regs smb_aux_checker #(.BUF_DEPTH(BUF_DEPTH)) i_chk (.mclk_i,
   .rst_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .eng_i,
   .own_addr_match_o, .device_error_set_o, .crc_auto_append_o, .block_buffer_enable_o,
   .tx_pec_o, .buf_byte_o, .block_done_o);
`default_nettype wire
